// ---- verilog/iocu_control.sv ----
// Control register with acknowledge-based update protocol for the translation unit.
// Function
// - Check mode zero passes translated traffic unchecked.
// - Check mode one checks stream permission field.
// - Bit 3 enables command queue, resets zero.
// - Bit 2 enables event queue writes, resets zero.
// - Bit 1 enables page request writes.
// - Bit 0 clear makes streams bypass.
// - Every non-reserved field has an acknowledge mirror.
// - Fields update independently of each other.
// - Update ends after side effects finish.
// - New value takes effect before update completes.
// - Reads return written value immediately.
// - Mid-update change ignored or update abandoned.
// - Wildcard acks after invalidation logic uses it.
// - Check mode acks after fetches use it.
// - Command disable drains in-flight commands first.
// - Command enable starts on non-empty, error-free queue.
// - Event disable acks after records visible.
// - Effective page enable zero while untranslated.
// - Page disable acks after records visible.
module iocu_control (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Register port.
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  // Command queue status.
  input  wire logic        command_queue_nonempty,
  input  wire logic        command_queue_error,
  input  wire logic        command_in_flight,
  // Event and page request queue status.
  input  wire logic        event_records_pending,
  input  wire logic        event_queue_abort_error,
  input  wire logic        page_records_pending,
  // Translation datapath status.
  input  wire logic        config_fetch_busy,
  input  wire logic        tlb_invalidate_busy,
  // Effective controls.
  output logic             command_fetch,
  output logic             event_queue_write_enable,
  output logic             page_request_write_enable,
  output logic             page_request_discard,
  output logic             translation_active,
  output logic             translated_lookup,
  output logic [2:0]       vm_id_wildcard
);
  // ****************************************************************
  // Written control value
  // ****************************************************************
  logic [31:0] translation_control;
  logic [31:0] next_translation_control;
  logic [31:0] control_acknowledge;
  logic [31:0] next_reg_rdata;
  logic        next_reg_rvalid;

  // Stores writes; reserved bits stay zero.
  always_comb begin
    next_translation_control = translation_control;
    if (reg_write && reg_addr == iocu_pkg::CONTROL_OFFSET) begin
      next_translation_control = reg_wdata & iocu_pkg::WRITABLE_MASK;
    end
  end

  // Read mux returns the written value even mid-update; unmapped reads give zero.
  always_comb begin
    next_reg_rdata  = 32'h0000_0000;
    next_reg_rvalid = reg_read;
    if (reg_read && reg_addr == iocu_pkg::CONTROL_OFFSET) begin
      next_reg_rdata = translation_control;
    end else if (reg_read && reg_addr == iocu_pkg::ACKNOWLEDGE_OFFSET) begin
      next_reg_rdata = control_acknowledge;
    end
  end

  // Registers the control word and the read answer.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      translation_control <= iocu_pkg::CONTROL_RESET;
      reg_rdata           <= 32'h0000_0000;
      reg_rvalid          <= 1'b0;
    end else begin
      translation_control <= next_translation_control;
      reg_rdata           <= next_reg_rdata;
      reg_rvalid          <= next_reg_rvalid;
    end
  end

  // ****************************************************************
  // Per-field update sequencers
  // ****************************************************************
  logic [iocu_pkg::FIELD_COUNT-2:0] single_effective;
  logic [iocu_pkg::FIELD_COUNT-2:0] single_ack;
  logic [iocu_pkg::FIELD_COUNT-2:0] single_written;
  logic [iocu_pkg::FIELD_COUNT-2:0] single_drained;
  logic [2:0]                       wildcard_effective;
  logic [2:0]                       wildcard_ack;

  // Written single-bit fields, indexed 0..4 as bits 0..4.
  assign single_written = translation_control[iocu_pkg::TRANSLATED_CHECK_BIT:0];

  // Side effects that must finish before each field acknowledges.
  always_comb begin
    single_drained = '0;
    // Translation enable: effective page enable must have fallen too.
    single_drained[iocu_pkg::TRANSLATION_ENABLE_BIT] = !page_records_pending;
    // Page requests: committed records visible.
    single_drained[iocu_pkg::PAGE_REQUEST_BIT] = !page_records_pending;
    // Events: records visible, abort reported.
    single_drained[iocu_pkg::EVENT_QUEUE_BIT] = !event_records_pending;
    // Commands: in-flight commands consumed, reads done.
    single_drained[iocu_pkg::COMMAND_QUEUE_BIT] = !command_in_flight;
    // Check mode: no fetch using the old mode outstanding.
    single_drained[iocu_pkg::TRANSLATED_CHECK_BIT] = !config_fetch_busy;
  end

  // One independent sequencer per field.
  genvar g;
  generate
    for (g = 0; g < iocu_pkg::FIELD_COUNT - 1; g++) begin : g_field
      iocu_field_update #(
        .WIDTH (1)
      ) u_field (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .written   (single_written[g]),
        .drained   (single_drained[g]),
        .effective (single_effective[g]),
        .ack       (single_ack[g])
      );
    end
  endgenerate

  // Wildcard waits for invalidation logic to go idle.
  iocu_field_update #(
    .WIDTH (3)
  ) u_wildcard (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .written   (translation_control[iocu_pkg::WILDCARD_MSB:iocu_pkg::WILDCARD_LSB]),
    .drained   (!tlb_invalidate_busy),
    .effective (wildcard_effective),
    .ack       (wildcard_ack)
  );

  // Acknowledge word; reserved bits never mirrored.
  always_comb begin
    control_acknowledge = 32'h0000_0000;
    control_acknowledge[iocu_pkg::TRANSLATED_CHECK_BIT:0] = single_ack;
    control_acknowledge[iocu_pkg::WILDCARD_MSB:iocu_pkg::WILDCARD_LSB] = wildcard_ack;
  end

  // ****************************************************************
  // Effective controls
  // ****************************************************************
  logic next_command_fetch;
  logic next_event_write;
  logic next_page_write;
  logic next_page_discard;
  logic next_translation_active;
  logic next_translated_lookup;
  logic page_effective;

  // Page enable is forced off while translation is off.
  assign page_effective = single_effective[iocu_pkg::PAGE_REQUEST_BIT]
                        & single_effective[iocu_pkg::TRANSLATION_ENABLE_BIT];

  // Derives the effective outputs from the live field values.
  always_comb begin
    // Fetch only when enabled, queue non-empty and no error.
    next_command_fetch = single_effective[iocu_pkg::COMMAND_QUEUE_BIT]
                       & command_queue_nonempty & !command_queue_error;
    next_event_write   = single_effective[iocu_pkg::EVENT_QUEUE_BIT]
                       & !event_queue_abort_error;
    next_page_write    = page_effective;
    next_page_discard  = !page_effective;
    next_translation_active = single_effective[iocu_pkg::TRANSLATION_ENABLE_BIT];
    // Zero passes translated traffic; one looks up the stream entry.
    next_translated_lookup = single_effective[iocu_pkg::TRANSLATED_CHECK_BIT];
  end

  // Registers the effective outputs.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      command_fetch             <= 1'b0;
      event_queue_write_enable  <= 1'b0;
      page_request_write_enable <= 1'b0;
      page_request_discard      <= 1'b1;
      translation_active        <= 1'b0;
      translated_lookup         <= 1'b0;
      vm_id_wildcard            <= iocu_pkg::WILDCARD_ZERO;
    end else begin
      command_fetch             <= next_command_fetch;
      event_queue_write_enable  <= next_event_write;
      page_request_write_enable <= next_page_write;
      page_request_discard      <= next_page_discard;
      translation_active        <= next_translation_active;
      translated_lookup         <= next_translated_lookup;
      vm_id_wildcard            <= wildcard_effective;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_no_fetch_disabled: assert property (@(posedge sys_clk) disable iff (srst)
    command_fetch |-> $past(single_effective[iocu_pkg::COMMAND_QUEUE_BIT]))
    else $error("Command fetched while disabled.");
  a_page_forced_off: assert property (@(posedge sys_clk) disable iff (srst)
    !$past(single_effective[iocu_pkg::TRANSLATION_ENABLE_BIT]) |-> !page_request_write_enable)
    else $error("Page writes enabled while translation off.");
  a_read_live_value: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_read && reg_addr == iocu_pkg::CONTROL_OFFSET) |=> reg_rdata == $past(translation_control))
    else $error("Control read did not return written value.");
  a_cmd_drain_ack: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(single_ack[iocu_pkg::COMMAND_QUEUE_BIT]) |-> $past(!command_in_flight, 2))
    else $error("Command disable acknowledged with commands in flight.");
  a_event_drain_ack: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(single_ack[iocu_pkg::EVENT_QUEUE_BIT]) |-> $past(!event_records_pending, 2))
    else $error("Event disable acknowledged with records pending.");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (srst)
    (control_acknowledge & ~iocu_pkg::WRITABLE_MASK) == 32'h0000_0000)
    else $error("Reserved acknowledge bit set.");
  // Once the check mode acknowledges, translated traffic must already use the new mode.
  a_check_mode_out: assert property (@(posedge sys_clk) disable iff (srst)
    $changed(single_ack[iocu_pkg::TRANSLATED_CHECK_BIT]) |->
      translated_lookup == single_ack[iocu_pkg::TRANSLATED_CHECK_BIT])
    else $error("Lookup mode does not follow acknowledged check bit.");
  a_translate_out: assert property (@(posedge sys_clk) disable iff (srst)
    translation_active == $past(single_effective[iocu_pkg::TRANSLATION_ENABLE_BIT]))
    else $error("Translation enable not followed.");
endmodule : iocu_control

// ---- verilog/iocu_pkg.sv ----
// Package with register offsets, field positions and reset values of the control block.
package iocu_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] CONTROL_OFFSET     = 12'h020;
  localparam logic [11:0] ACKNOWLEDGE_OFFSET = 12'h024;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TRANSLATION_ENABLE_BIT = 0;
  localparam int PAGE_REQUEST_BIT       = 1;
  localparam int EVENT_QUEUE_BIT        = 2;
  localparam int COMMAND_QUEUE_BIT      = 3;
  localparam int TRANSLATED_CHECK_BIT   = 4;
  localparam int WILDCARD_LSB           = 6;
  localparam int WILDCARD_MSB           = 8;
  localparam int FIELD_COUNT            = 6;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] WRITABLE_MASK = 32'h0000_01DF;
  localparam logic [2:0]  WILDCARD_ZERO = 3'h0;

  // States of the per-field update sequencer.
  typedef enum logic [2:0] {
    IOCU_IDLE  = 3'b001,
    IOCU_DRAIN = 3'b010,
    IOCU_DONE  = 3'b100
  } iocu_state_e;
endpackage : iocu_pkg

// ---- verilog/iocu_field_update.sv ----
// One control field update sequencer: waits for side effects, then acknowledges.
module iocu_field_update #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Written value and side-effect handshake.
  input  wire logic [WIDTH-1:0] written,
  input  wire logic             drained,
  // Effective value and acknowledge.
  output logic      [WIDTH-1:0] effective,
  output logic      [WIDTH-1:0] ack
);
  // ****************************************************************
  // Sequencer
  // ****************************************************************
  iocu_pkg::iocu_state_e state;
  iocu_pkg::iocu_state_e next_state;
  logic [WIDTH-1:0]      target;
  logic [WIDTH-1:0]      next_target;
  logic [WIDTH-1:0]      next_effective;
  logic [WIDTH-1:0]      next_ack;

  // Computes the next state; a second change mid-update is ignored unless it restores the old value.
  always_comb begin
    next_state     = state;
    next_target    = target;
    next_effective = effective;
    next_ack       = ack;
    case (state)
      iocu_pkg::IOCU_IDLE: begin
        if (written != ack) begin
          next_target    = written;
          next_effective = written; // New value goes live at once.
          next_state     = iocu_pkg::IOCU_DRAIN;
        end
      end
      iocu_pkg::IOCU_DRAIN: begin
        if (written == ack && written != target) begin
          next_effective = ack; // Abandon when the old value is written back.
          next_state     = iocu_pkg::IOCU_IDLE;
        end else if (drained) begin
          next_state = iocu_pkg::IOCU_DONE; // Side effects are complete.
        end
      end
      iocu_pkg::IOCU_DONE: begin
        next_ack   = target; // Acknowledge mirrors the committed value.
        next_state = iocu_pkg::IOCU_IDLE;
      end
      default: begin
        next_state = iocu_pkg::IOCU_IDLE;
      end
    endcase
  end

  // Registers the sequencer; reset loads idle and zeroes target, effective value and ack.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state     <= iocu_pkg::IOCU_IDLE;
      target    <= '0;
      effective <= '0;
      ack       <= '0;
    end else begin
      state     <= next_state;
      target    <= next_target;
      effective <= next_effective;
      ack       <= next_ack;
    end
  end

  // Acknowledge only moves after a drained cycle.
  a_ack_after_drain: assert property (@(posedge sys_clk) disable iff (srst)
    (ack != $past(ack)) |-> $past(state == iocu_pkg::IOCU_DONE))
    else $error("Acknowledge changed without completed update.");
endmodule : iocu_field_update

// ---- sim/testbench.sv ----
// Self-checking testbench for the control register and its acknowledge protocol.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        sys_clk, srst, reg_write, reg_read, reg_rvalid;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic        q_nonempty, q_error, in_flight, ev_pend, ev_abort, pg_pend, cfg_busy, tlb_busy;
  logic        command_fetch, event_queue_write_enable, page_request_write_enable;
  logic        page_request_discard, translation_active, translated_lookup;
  logic [2:0]  vm_id_wildcard;
  logic [8:0]  eff;
  int          errors, n_tests;

  // All effective controls in one vector, fetch in the top bit.
  assign eff = {command_fetch, event_queue_write_enable, page_request_write_enable, page_request_discard,
                translation_active, translated_lookup, vm_id_wildcard};

  iocu_control dut_u (
    .sys_clk(sys_clk), .srst(srst), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .command_queue_nonempty(q_nonempty), .command_queue_error(q_error), .command_in_flight(in_flight),
    .event_records_pending(ev_pend), .event_queue_abort_error(ev_abort), .page_records_pending(pg_pend),
    .config_fetch_busy(cfg_busy), .tlb_invalidate_busy(tlb_busy), .command_fetch(command_fetch),
    .event_queue_write_enable(event_queue_write_enable), .page_request_write_enable(page_request_write_enable),
    .page_request_discard(page_request_discard), .translation_active(translation_active),
    .translated_lookup(translated_lookup), .vm_id_wildcard(vm_id_wildcard));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Write strobe stands for exactly one sampling edge.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr

  // Read strobe for one edge; the valid pulse must follow at once and data is taken while it stands.
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk("read valid", {31'h0, reg_rvalid}, 32'h0000_0001);
    d = reg_rdata;
  endtask : rd

  // Polls the acknowledge register a bounded number of times for a value.
  task automatic poll_ack(input string nm, input logic [31:0] exp);
    int n;
    n = 0;
    rd(iocu_pkg::ACKNOWLEDGE_OFFSET, rv);
    while (rv !== exp && n < 20) begin
      rd(iocu_pkg::ACKNOWLEDGE_OFFSET, rv);
      n++;
    end
    chk(nm, rv, exp);
  endtask : poll_ack

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Clock, reset and watchdog
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Cuts a hang short well after the expected hundred or so cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    wrap_up();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    errors = 0; n_tests = 0; srst = 1'b1; reg_write = 1'b0; reg_read = 1'b0; reg_addr = 12'h000;
    reg_wdata = 32'h0; q_nonempty = 1'b1; q_error = 1'b0; in_flight = 1'b1; ev_pend = 1'b1;
    ev_abort = 1'b0; pg_pend = 1'b1; cfg_busy = 1'b1; tlb_busy = 1'b1;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    // Reset values, an ignored write elsewhere and an unmapped read.
    wr(12'h030, 32'hFFFF_FFFF);
    rd(iocu_pkg::CONTROL_OFFSET, rv);
    chk("control", rv, 32'h0000_0000);
    rd(iocu_pkg::ACKNOWLEDGE_OFFSET, rv);
    chk("acknowledge", rv, 32'h0000_0000);
    rd(12'h028, rv);
    chk("unmapped", rv, 32'h0000_0000);
    chk("effective", {23'h0, eff}, 32'h0000_0020);
    $display("test reset done");
    // Every field written, reserved bits dropped, acks gated by each drain.
    wr(iocu_pkg::CONTROL_OFFSET, 32'hFFFF_FEBF);
    rd(iocu_pkg::CONTROL_OFFSET, rv);
    chk("control", rv, 32'h0000_009F);
    repeat (6) @(posedge sys_clk);
    rd(iocu_pkg::ACKNOWLEDGE_OFFSET, rv);
    chk("acknowledge", rv, 32'h0000_0000);
    tlb_busy <= 1'b0;
    poll_ack("ack wildcard", 32'h0000_0080);
    cfg_busy <= 1'b0;
    poll_ack("ack check", 32'h0000_0090);
    in_flight <= 1'b0;
    poll_ack("ack command", 32'h0000_0098);
    ev_pend <= 1'b0;
    poll_ack("ack event", 32'h0000_009C);
    pg_pend <= 1'b0;
    poll_ack("ack page", 32'h0000_009F);
    chk("effective", {23'h0, eff}, 32'h0000_01DA);
    q_error <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("effective", {23'h0, eff}, 32'h0000_00DA);
    q_error <= 1'b0;
    q_nonempty <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("effective", {23'h0, eff}, 32'h0000_00DA);
    q_nonempty <= 1'b1;
    ev_abort <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("effective", {23'h0, eff}, 32'h0000_015A);
    ev_abort <= 1'b0;
    $display("test all fields done");
    // Translation off with page requests still on; written only after every ack matched.
    wr(iocu_pkg::CONTROL_OFFSET, 32'h0000_0002);
    poll_ack("ack page only", 32'h0000_0002);
    chk("effective", {23'h0, eff}, 32'h0000_0020);
    $display("test translation off done");
    // A change reverted mid-update is abandoned; the drain is held off so a kept first value would show.
    ev_pend <= 1'b1;
    wr(iocu_pkg::CONTROL_OFFSET, 32'h0000_0006);
    wr(iocu_pkg::CONTROL_OFFSET, 32'h0000_0002);
    repeat (6) @(posedge sys_clk);
    rd(iocu_pkg::ACKNOWLEDGE_OFFSET, rv);
    chk("ack abandon", rv, 32'h0000_0002);
    rd(iocu_pkg::CONTROL_OFFSET, rv);
    chk("control", rv, 32'h0000_0002);
    chk("effective", {23'h0, eff}, 32'h0000_0020);
    ev_pend <= 1'b0;
    $display("test abandon done");
    wrap_up();
  end
endmodule : testbench
